//--- src/homing_params.svh
// constants for the count-method homing sequencer
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_METHOD 12'h004
`define OFF_HOME_POS 12'h008
`define OFF_HOMING_SPEED 12'h00c
`define OFF_CREEP_SPEED 12'h010
`define OFF_POST_DOG 12'h014
`define OFF_AXIS_STATUS 12'h018
`define OFF_HOME_ABS 12'h01c
`define OFF_CUR_FEED 12'h020
`define OFF_MACH_FEED 12'h024
`define OFF_IRQ_STATUS 12'h028
`define OFF_IRQ_MASK 12'h02c
`define OFF_ERROR 12'h030
`define OFF_REV_COUNTS 12'h034
// control bits
`define CTRL_START_BIT 0
`define CTRL_ABORT_BIT 1
// axis status word bits
`define ST_BUSY_BIT 0
`define ST_ERR_BIT 1
`define ST_REQ_BIT 3
`define ST_DONE_BIT 4
// interrupt status bits
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
// method codes
`define METHOD_COUNT1 3'h4
`define METHOD_COUNT2 3'h5
`define METHOD_COUNT3 3'h6
`define METHOD_DATASET 3'h3
// error code for no zero pulse found
`define ERR_NO_ZERO 16'h00d2
// reset values
`define RST_REV_COUNTS 32'h00001000
`endif

//--- src/homing_pkg.sv
// types for the count-method homing sequencer
package homing_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FAST = 4'h1,
    ST_CREEP = 4'h3,
    ST_SEEK = 4'h2,
    ST_DONE = 4'h6,
    ST_REV = 4'h7,
    ST_RETURN = 4'h5,
    ST_RCREEP = 4'h4,
    ST_FAIL = 4'hc
  } home_state_t;
  typedef enum logic [1:0] {
    SPD_STOP = 2'h0,
    SPD_HOMING = 2'h1,
    SPD_CREEP = 2'h2
  } speed_sel_t;
endpackage : homing_pkg

//--- src/count_method_homing_sequencer.sv
// count-method homing sequencer with apb register file
//
// Summary of operation
// R1 - count 1: dog on, decelerate to creep
// R2 - count 1: after distance, stop at zero pulse
// R3 - count 1: no pulse, stop at dog off, error 210
// R4 - count 2: stop exactly at post-dog distance
// R5 - count 3 with pulse: same as count 1
// R6 - count 3 no pulse: finish distance, reverse one turn
// R7 - count 3: homing speed, distance after dog off, pulse
// R8 - data setting: load zero address into feeds
// R9 - amplifier gives one zero pulse per revolution
// R10 - always creep before final stop
// R11 - done sets status bit 4, clears bit 3
// R12 - completion loads zero address into monitors
// R13 - method parameter selects; stray pulses ignored
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "homing_params.svh"

module count_method_homing_sequencer #(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // axis inputs
  input wire logic DOG_IN,
  input wire logic ZERO_PULSE,
  input wire logic FEED_PULSE,
  // motion command
  output homing_pkg::speed_sel_t SPEED_SEL,
  output logic [31:0] SPEED_CMD,
  output logic DIR_REVERSE,
  output logic HOMING_BUSY,
  // interrupt
  output logic IRQ
);
  import homing_pkg::*;

  initial begin
    if (POS_W < 8 || POS_W > 32) $error("POS_W out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] method_r;
  logic [31:0] home_pos_r, homing_speed_r, creep_speed_r, post_dog_r, rev_counts_r;
  logic [31:0] home_abs_r, cur_feed_r, mach_feed_r;
  logic req_r, done_r, err_r;
  logic [15:0] err_code_r;
  logic [1:0] irq_st_r, irq_mask_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;
  home_state_t state_r, state_nxt;
  logic [31:0] dist_r, dist_nxt;
  logic zero_seen_r, zero_seen_nxt, dog_d_r;
  speed_sel_t speed_r, speed_nxt;
  logic dir_r, dir_nxt;
  logic [31:0] speed_cmd_r;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic setup = PSEL & ~PENABLE;
  // writes land in the access phase, at the edge where the master sees ready
  wire logic access = PSEL & PENABLE & pready_r;
  wire logic wr = access & PWRITE;
  wire logic rd = setup & ~PWRITE;
  wire logic hit_ctrl = PADDR == `OFF_CTRL;
  wire logic hit_method = PADDR == `OFF_METHOD;
  wire logic hit_home = PADDR == `OFF_HOME_POS;
  wire logic hit_hspd = PADDR == `OFF_HOMING_SPEED;
  wire logic hit_cspd = PADDR == `OFF_CREEP_SPEED;
  wire logic hit_post = PADDR == `OFF_POST_DOG;
  wire logic hit_stat = PADDR == `OFF_AXIS_STATUS;
  wire logic hit_habs = PADDR == `OFF_HOME_ABS;
  wire logic hit_cur = PADDR == `OFF_CUR_FEED;
  wire logic hit_mach = PADDR == `OFF_MACH_FEED;
  wire logic hit_ist = PADDR == `OFF_IRQ_STATUS;
  wire logic hit_imask = PADDR == `OFF_IRQ_MASK;
  wire logic hit_err = PADDR == `OFF_ERROR;
  wire logic hit_rev = PADDR == `OFF_REV_COUNTS;
  wire logic mapped = hit_ctrl | hit_method | hit_home | hit_hspd | hit_cspd | hit_post
    | hit_stat | hit_habs | hit_cur | hit_mach | hit_ist | hit_imask | hit_err | hit_rev;
  wire logic start = wr & hit_ctrl & PWDATA[`CTRL_START_BIT];
  wire logic abort = wr & hit_ctrl & PWDATA[`CTRL_ABORT_BIT];
  wire logic [31:0] status_word = {27'h0, done_r, req_r, 1'b0, err_r, HOMING_BUSY};
  wire logic [31:0] rd_mux =
    hit_method ? {29'h0, method_r} :
    hit_home ? home_pos_r :
    hit_hspd ? homing_speed_r :
    hit_cspd ? creep_speed_r :
    hit_post ? post_dog_r :
    hit_stat ? status_word :
    hit_habs ? home_abs_r :
    hit_cur ? cur_feed_r :
    hit_mach ? mach_feed_r :
    hit_ist ? {30'h0, irq_st_r} :
    hit_imask ? {30'h0, irq_mask_r} :
    hit_err ? {16'h0, err_code_r} :
    hit_rev ? rev_counts_r : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // sequencer
  wire logic is_c1 = method_r == `METHOD_COUNT1;
  wire logic is_c2 = method_r == `METHOD_COUNT2;
  wire logic is_c3 = method_r == `METHOD_COUNT3;
  wire logic is_ds = method_r == `METHOD_DATASET;
  wire logic dog_rise = DOG_IN & ~dog_d_r;
  wire logic dog_fall = ~DOG_IN & dog_d_r;
  wire logic dist_hit = dist_r >= post_dog_r;
  wire logic dist_step = FEED_PULSE & ~dist_hit;
  wire logic finish_ok = state_r == ST_DONE;
  wire logic finish_err = state_r == ST_FAIL;
  wire logic [31:0] dist_inc = dist_r + 32'h1;

  always_comb begin
    state_nxt = state_r;
    dist_nxt = dist_r;
    zero_seen_nxt = zero_seen_r;
    speed_nxt = speed_r;
    dir_nxt = dir_r;
    unique case (state_r)
      ST_IDLE: begin
        dist_nxt = 32'h0;
        zero_seen_nxt = 1'b0;
        dir_nxt = 1'b0;
        if (start && is_ds) begin
          state_nxt = ST_DONE; // [R8]
        end else if (start && (is_c1 || is_c2 || is_c3)) begin // [R13]
          state_nxt = DOG_IN ? ST_CREEP : ST_FAST;
          speed_nxt = DOG_IN ? SPD_CREEP : SPD_HOMING;
        end
      end
      ST_FAST: begin
        if (dog_rise) begin
          state_nxt = ST_CREEP;
          speed_nxt = SPD_CREEP; // [R1]
        end
      end
      ST_CREEP: begin
        if (dist_step) dist_nxt = dist_inc;
        if (ZERO_PULSE) zero_seen_nxt = 1'b1; // [R13]
        if (dist_hit) begin
          if (is_c2) begin
            state_nxt = ST_DONE;
            speed_nxt = SPD_STOP; // [R4]
          end else if (zero_seen_r || !is_c3) begin
            state_nxt = ST_SEEK; // [R2] [R5]
          end else begin
            state_nxt = ST_REV;
            dist_nxt = 32'h0;
            dir_nxt = 1'b1;
            speed_nxt = SPD_HOMING; // [R6]
          end
        end
      end
      ST_SEEK: begin
        if (ZERO_PULSE && zero_seen_r) begin
          state_nxt = ST_DONE;
          speed_nxt = SPD_STOP; // [R2] [R10]
        end else if (dog_fall && !zero_seen_r) begin
          state_nxt = ST_FAIL;
          speed_nxt = SPD_STOP; // [R3]
        end else if (ZERO_PULSE && !is_c3) begin
          zero_seen_nxt = 1'b1;
        end
      end
      ST_REV: begin
        if (FEED_PULSE) dist_nxt = dist_inc;
        if (dist_r >= rev_counts_r) begin
          state_nxt = ST_RETURN;
          dir_nxt = 1'b0;
          dist_nxt = 32'h0; // [R6]
        end
      end
      ST_RETURN: begin
        if (dog_fall) state_nxt = ST_RCREEP; // [R7]
      end
      ST_RCREEP: begin
        if (dist_step) dist_nxt = dist_inc;
        if (dist_hit) speed_nxt = SPD_CREEP; // [R10]
        if (dist_hit && ZERO_PULSE && speed_r == SPD_CREEP) begin
          state_nxt = ST_DONE;
          speed_nxt = SPD_STOP; // [R7]
        end
      end
      ST_DONE, ST_FAIL: begin
        state_nxt = ST_IDLE;
        speed_nxt = SPD_STOP;
      end
      default: begin
        state_nxt = ST_IDLE;
        speed_nxt = SPD_STOP;
      end
    endcase
    if (abort) begin
      state_nxt = ST_IDLE;
      speed_nxt = SPD_STOP;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_r <= ST_IDLE;
      dist_r <= 32'h0;
      zero_seen_r <= 1'b0;
      speed_r <= SPD_STOP;
      dir_r <= 1'b0;
      dog_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dist_r <= dist_nxt;
      zero_seen_r <= zero_seen_nxt;
      speed_r <= speed_nxt;
      dir_r <= dir_nxt;
      dog_d_r <= DOG_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      method_r <= `METHOD_COUNT1;
      home_pos_r <= 32'h0;
      homing_speed_r <= 32'h0;
      creep_speed_r <= 32'h0;
      post_dog_r <= 32'h0;
      rev_counts_r <= `RST_REV_COUNTS;
      irq_mask_r <= 2'h0;
    end else if (wr) begin
      if (hit_method) method_r <= PWDATA[2:0];
      if (hit_home) home_pos_r <= PWDATA;
      if (hit_hspd) homing_speed_r <= PWDATA;
      if (hit_cspd) creep_speed_r <= PWDATA;
      if (hit_post) post_dog_r <= PWDATA;
      if (hit_rev) rev_counts_r <= PWDATA;
      if (hit_imask) irq_mask_r <= PWDATA[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status, monitors and interrupt
  wire logic [1:0] irq_ev = {finish_err, finish_ok};
  wire logic [1:0] irq_clr = (wr && hit_ist) ? PWDATA[1:0] : 2'h0;
  wire logic [1:0] irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;
  wire logic moving = FEED_PULSE && speed_r != SPD_STOP;
  wire logic [31:0] cur_step = dir_r ? cur_feed_r - 32'h1 : cur_feed_r + 32'h1;
  wire logic [31:0] mach_step = dir_r ? mach_feed_r - 32'h1 : mach_feed_r + 32'h1;

  // completion outranks a start written in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      req_r <= 1'b1;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else if (finish_ok) begin
      done_r <= 1'b1;
      req_r <= 1'b0; // [R11]
    end else if (finish_err) begin
      err_r <= 1'b1; // [R3]
    end else if (start) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      req_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      err_code_r <= 16'h0;
    end else if (finish_err) begin
      err_code_r <= `ERR_NO_ZERO; // [R3]
    end
  end

  // monitors track feed pulses and take the home address on completion
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      home_abs_r <= 32'h0;
      cur_feed_r <= 32'h0;
      mach_feed_r <= 32'h0;
    end else if (finish_ok) begin
      home_abs_r <= home_pos_r;
      cur_feed_r <= home_pos_r;
      mach_feed_r <= home_pos_r; // [R8] [R12]
    end else if (moving) begin
      cur_feed_r <= cur_step;
      mach_feed_r <= mach_step;
    end
  end

  // an event in the same cycle as its clear wins
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_st_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_r <= |(irq_st_nxt & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs and apb answer
  wire logic [31:0] speed_val = speed_nxt == SPD_HOMING ? homing_speed_r :
    speed_nxt == SPD_CREEP ? creep_speed_r : 32'h0;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= rd ? rd_mux : 32'h0;
    end
  end

  // speed value is registered alongside the selector it belongs to
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      speed_cmd_r <= 32'h0;
    end else begin
      speed_cmd_r <= speed_val;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign SPEED_SEL = speed_r;
  assign SPEED_CMD = speed_cmd_r;
  assign DIR_REVERSE = dir_r;
  assign IRQ = irq_r;
  assign HOMING_BUSY = state_r != ST_IDLE;
endmodule : count_method_homing_sequencer

//--- dv/axis_model.sv
// servo amplifier and near-point dog model
`timescale 1ns/100ps
module axis_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench control
  input wire logic home,
  input wire logic zero_en,
  // motion command
  input wire logic [1:0] speed_sel,
  input wire logic dir_reverse,
  // sensors
  output logic dog,
  output logic zero,
  output logic feed,
  output logic [15:0] pos
);
  logic [1:0] div_r;
  logic tick;
  // creep moves one unit every fourth cycle
  assign tick = speed_sel == 2'h1 || (speed_sel == 2'h2 && div_r == 2'h0);
  assign dog = pos >= 16'h0014 && pos < 16'h003c;
  always_ff @(posedge clk) begin
    div_r <= div_r + 2'h1;
    feed <= tick && !srst;
    zero <= tick && zero_en && pos[3:0] == 4'h7 && !srst;
    if (srst || home) begin
      pos <= 16'h0000;
    end else if (tick) begin
      pos <= dir_reverse ? pos - 16'h0001 : pos + 16'h0001;
    end
  end
endmodule : axis_model

//--- dv/count_method_homing_sequencer_asserts.sv
// port assertions for the homing sequencer
`timescale 1ns/100ps
`include "homing_params.svh"
module homing_seq_asserts (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // axis
  input wire logic DOG_IN,
  input wire logic ZERO_PULSE,
  input wire homing_pkg::speed_sel_t SPEED_SEL,
  input wire logic DIR_REVERSE,
  input wire logic HOMING_BUSY
);
  import homing_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////
  sequence s_start;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == `OFF_CTRL && PWDATA[0] && !HOMING_BUSY;
  endsequence
  sequence s_dog_hit;
    $rose(DOG_IN) && SPEED_SEL == SPD_HOMING && !DIR_REVERSE;
  endsequence
  chk_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_start_busy: assert property (s_start |=> HOMING_BUSY)
    else $error("start did not set busy");
  chk_dog_creep: assert property (s_dog_hit |=> SPEED_SEL == SPD_CREEP)
    else $error("no creep after dog on");
  chk_fast_stop: assert property (SPEED_SEL == SPD_HOMING && !DIR_REVERSE |=> SPEED_SEL != SPD_STOP)
    else $error("stop from homing speed");
  chk_stop_creep: assert property ($fell(HOMING_BUSY) |-> $past(SPEED_SEL) != SPD_HOMING)
    else $error("finished from homing speed");
  chk_stray_zero: assert property (ZERO_PULSE && SPEED_SEL == SPD_HOMING && !DIR_REVERSE |=> HOMING_BUSY)
    else $error("zero pulse ended approach");
  chk_idle_stop: assert property (!HOMING_BUSY |-> SPEED_SEL == SPD_STOP && !DIR_REVERSE)
    else $error("motion while idle");
  chk_rev_moving: assert property (DIR_REVERSE |-> SPEED_SEL != SPD_STOP && HOMING_BUSY)
    else $error("reverse without motion");
endmodule : homing_seq_asserts

bind count_method_homing_sequencer homing_seq_asserts u_chk (.CORE_CLK, .SRST, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .DOG_IN, .ZERO_PULSE, .SPEED_SEL,
  .DIR_REVERSE, .HOMING_BUSY);

//--- dv/count_method_homing_sequencer_tb_top.sv
// self-checking bench for the homing sequencer
`timescale 1ns/100ps
`include "homing_params.svh"
module count_method_homing_sequencer_tb_top;
  import homing_pkg::*;
  logic clk, srst, psel, pen, pwr, ready, slv, er, dog, zero, feed, dirr, busy, irq, home, zen, rv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, scmd, rnd, hp, hs, cs, cr;
  logic [15:0] pos;
  logic [2:0] meth [5];
  speed_sel_t ssel;
  int n_mismatch, compares, cyc;
  count_method_homing_sequencer dut (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(ready),
    .PSLVERR(slv), .DOG_IN(dog), .ZERO_PULSE(zero), .FEED_PULSE(feed), .SPEED_SEL(ssel),
    .SPEED_CMD(scmd), .DIR_REVERSE(dirr), .HOMING_BUSY(busy), .IRQ(irq));
  axis_model u_axis (.clk(clk), .srst(srst), .home(home), .zero_en(zen), .speed_sel(ssel),
    .dir_reverse(dirr), .dog(dog), .zero(zero), .feed(feed), .pos(pos));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // stop position for the model's dog window, distance 30 and zero at 7 mod 16
  function automatic logic near(input logic [15:0] p, input logic [2:0] m);
    int e;
    e = m == `METHOD_COUNT1 ? 56 : m == `METHOD_COUNT2 ? 50 : 104;
    return int'(p) >= e - 2 && int'(p) <= e + 2;
  endfunction : near
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(negedge clk); while (ready !== 1'b1);
    rd = prdata;
    er = slv;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dirr === 1'b1) zen <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    meth = '{`METHOD_COUNT1, `METHOD_COUNT2, `METHOD_COUNT3, `METHOD_COUNT1, `METHOD_DATASET};
    {srst, psel, pen, pwr, home, zen} = 6'h20;
    paddr = 12'h0;
    pwdata = 32'h0;
    rnd = 32'h3;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rchk("revs", `OFF_REV_COUNTS, `RST_REV_COUNTS);
    rchk("hole", 12'hffc, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    apb(1'b1, `OFF_REV_COUNTS, 32'h10);
    apb(1'b1, `OFF_POST_DOG, 32'd30);
    for (int i = 0; i < 5; i++) begin
      rnd = xs(rnd);
      hp = rnd;
      rnd = xs(rnd);
      hs = rnd;
      cs = {16'h0, rnd[15:0]};
      home <= 1'b1;
      zen <= i < 2;
      apb(1'b1, `OFF_HOME_POS, hp);
      apb(1'b1, `OFF_HOMING_SPEED, hs);
      apb(1'b1, `OFF_CREEP_SPEED, cs);
      apb(1'b1, `OFF_IRQ_MASK, i == 4 ? 32'h0 : 32'h3);
      apb(1'b1, `OFF_METHOD, 32'(meth[i]));
      home <= 1'b0;
      rv = 1'b0;
      cr = 32'h0;
      apb(1'b1, `OFF_CTRL, 32'h1);
      @(negedge clk);
      if (i < 4) chk("cmd", hs, scmd);
      while (busy !== 1'b0) begin
        @(negedge clk);
        if (ssel === SPD_CREEP) cr = scmd;
        if (dirr === 1'b1) rv = 1'b1;
      end
      repeat (2) @(posedge clk);
      chk("rev", 32'(i == 2), 32'(rv));
      chk("irq", 32'(i != 4), 32'(irq));
      rchk("irqst", `OFF_IRQ_STATUS, i == 3 ? 32'h2 : 32'h1);
      apb(1'b1, `OFF_IRQ_STATUS, 32'h3);
      rchk("irqclr", `OFF_IRQ_STATUS, 32'h0);
      chk("irqlo", 32'h0, 32'(irq));
      apb(1'b0, `OFF_AXIS_STATUS, 32'h0);
      if (i == 3) begin
        chk("sterr", 32'h1, 32'(rd[`ST_ERR_BIT]));
        rchk("code", `OFF_ERROR, 32'(`ERR_NO_ZERO));
      end else begin
        chk("stdone", 32'h2, 32'(rd[4:3]));
        rchk("cur", `OFF_CUR_FEED, hp);
        rchk("mach", `OFF_MACH_FEED, hp);
        rchk("abs", `OFF_HOME_ABS, hp);
      end
      if (i < 3) begin
        chk("creep", cs, cr);
        chk("stop", 32'h1, 32'(near(pos, meth[i])));
      end
    end
    test_done();
  end
endmodule : count_method_homing_sequencer_tb_top
